/* File: hdl/fault_prot.v */
// Output fault supervisor with auto-restart, latch, APB registers and interrupt
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "fault_prot_defs.vh"

module fault_prot #(
  parameter VW = 12,
  parameter TW = 16,
  parameter RESTART_CYC = `RESTART_TIME_US * `CLK_MHZ
)(
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  input wire [VW-1:0] i_vin,
  input wire [VW-1:0] i_iout,
  input wire [TW-1:0] i_ton,
  input wire [TW-1:0] i_tpwm,
  input wire i_period_done,
  input wire i_on_start,
  input wire i_peak_cmp,
  input wire [VW-1:0] i_peak_thr_raw,
  input wire i_soft_start_done,
  input wire [VW-1:0] i_iref_meas,
  input wire i_int_temp_req,
  input wire [7:0] i_int_temp_level,
  input wire i_ext_temp_req,
  input wire [7:0] i_ext_temp_level,
  output wire o_buck_en,
  output reg o_gate,
  output reg o_ref_read_start,
  output reg [VW-1:0] o_ref_current,
  output reg [VW-1:0] o_peak_threshold,
  output reg [7:0] o_current_level,
  output wire o_irq
);
  // One-hot restart states
  localparam ST_RUN = 4'b0001;
  localparam ST_READ = 4'b0010;
  localparam ST_DELAY = 4'b0100;
  localparam ST_LATCH = 4'b1000;
  localparam PW = 2 * VW + TW;

  // First-order low-pass: y + (x - y) / 2^k
  function [PW+1:0] lp_filt;
    input [PW+1:0] y;
    input [PW+1:0] x;
    input [3:0] k;
    reg signed [PW+2:0] d;
    reg signed [PW+2:0] s;
    begin
      d = $signed({1'b0, x}) - $signed({1'b0, y});
      // Own statement keeps the shift arithmetic for a falling input
      s = d >>> k;
      lp_filt = y + s[PW+1:0];
    end
  endfunction

  reg [1:0] ctrl_ff;
  reg [15:0] vout_min_ff, vout_max_ff, pout_max_ff, open_tmo_ff, read_tmo_ff;
  reg [3:0] tpwm_coef_ff, pout_coef_ff;
  reg [VW-1:0] range_th_ff;
  reg [`EV_W-1:0] irq_stat_ff, irq_mask_ff;
  reg [3:0] state_ff;
  reg [2:0] tries_ff;
  reg open_fault_ff;
  reg [31:0] timer_ff;
  reg [TW-1:0] on_cnt_ff;
  reg on_ff;
  reg [PW+1:0] tpwm_f_ff, pout_f_ff, peak_f_ff;
  reg [`EV_W-1:0] ev;
  reg [3:0] nxt_state;

  wire wr = i_psel & i_penable & i_pwrite;
  wire setup = i_psel & ~i_penable;
  wire enabled = ctrl_ff[`CTRL_EN];
  wire in_run = state_ff[0];
  wire steady = in_run & i_soft_start_done;

  // APB decode: zero-wait, error on unmapped offsets
  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `REG_REF_CUR) && (a[1:0] == 2'b00);
    end
  endfunction
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped(i_paddr);

  // Duty-based estimates, cross-multiplied to avoid a divider
  wire [VW+TW-1:0] vout_num = i_vin * i_ton;
  wire [PW-1:0] pout_num = vout_num * i_iout;
  wire [PW+1:0] tpwm_x = {{(PW+2-TW){1'b0}}, i_tpwm};
  wire [PW+1:0] pout_x = {2'b00, pout_num};
  wire [TW-1:0] tpwm_f = tpwm_f_ff[TW-1:0];
  wire [16+TW-1:0] vmin_ref = vout_min_ff * tpwm_f;
  wire [16+TW-1:0] vmax_ref = vout_max_ff * tpwm_f;
  // Power limit for the range picked by the reference current
  wire [7:0] factor = (o_ref_current >= range_th_ff) ? `LIMIT_HC_FACTOR
                                                     : `LIMIT_LC_FACTOR;
  wire [23:0] lim_full = pout_max_ff * factor;
  wire [15:0] p_limit = lim_full[`FACTOR_SHIFT+15:`FACTOR_SHIFT];
  wire [16+TW-1:0] plim_ref = p_limit * tpwm_f;
  wire [PW+1:0] plim_x = {{(PW+2-16-TW){1'b0}}, plim_ref};
  wire [16+TW-1:0] vnum_x = {{(16-VW){1'b0}}, vout_num};

  // Fault detection, steady state only for voltage and power
  wire uv_det = steady & i_period_done & (vnum_x < vmin_ref);
  wire ov_det = steady & i_period_done & (vnum_x > vmax_ref);
  // Power is a level check: a stale high filter value refaults at once
  wire opw_det = steady & (pout_f_ff > plim_x);
  wire open_det = in_run & on_ff & ~i_peak_cmp & (on_cnt_ff >= open_tmo_ff);
  wire fault = enabled & (uv_det | ov_det | opw_det | open_det);

  assign o_buck_en = enabled & in_run;
  assign o_irq = |(irq_stat_ff & irq_mask_ff);

  // Register writes; hardware set beats software clear
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_ff <= `CTRL_RST;
      vout_min_ff <= `VOUT_MIN_RST;
      vout_max_ff <= `VOUT_MAX_RST;
      pout_max_ff <= `POUT_MAX_RST;
      open_tmo_ff <= `OPEN_TMO_RST;
      read_tmo_ff <= `READ_TMO_RST;
      tpwm_coef_ff <= `COEF_RST;
      pout_coef_ff <= `COEF_RST;
      range_th_ff <= `RANGE_TH_RST;
      irq_mask_ff <= {`EV_W{1'b0}};
      irq_stat_ff <= {`EV_W{1'b0}};
    end
    else
    begin
      if (wr)
      begin
        case (i_paddr)
          `REG_CTRL: ctrl_ff <= i_pwdata[1:0];
          `REG_VOUT_MIN: vout_min_ff <= i_pwdata[15:0];
          `REG_VOUT_MAX: vout_max_ff <= i_pwdata[15:0];
          `REG_POUT_MAX: pout_max_ff <= i_pwdata[15:0];
          `REG_OPEN_TMO: open_tmo_ff <= i_pwdata[15:0];
          `REG_READ_TMO: read_tmo_ff <= i_pwdata[15:0];
          `REG_TPWM_COEF: tpwm_coef_ff <= i_pwdata[3:0];
          `REG_POUT_COEF: pout_coef_ff <= i_pwdata[3:0];
          `REG_RANGE_TH: range_th_ff <= i_pwdata[VW-1:0];
          `REG_IRQ_MASK: irq_mask_ff <= i_pwdata[`EV_W-1:0];
          default: ;
        endcase
      end
      if (wr && i_paddr == `REG_IRQ_STAT)
        irq_stat_ff <= (irq_stat_ff & ~i_pwdata[`EV_W-1:0]) | ev;
      else
        irq_stat_ff <= irq_stat_ff | ev;
    end
  end

  // Read data captured in the setup phase
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_prdata <= 32'h00000000;
    else if (setup)
    begin
      case (i_paddr)
        `REG_CTRL: o_prdata <= {30'h0, ctrl_ff};
        `REG_VOUT_MIN: o_prdata <= {16'h0, vout_min_ff};
        `REG_VOUT_MAX: o_prdata <= {16'h0, vout_max_ff};
        `REG_POUT_MAX: o_prdata <= {16'h0, pout_max_ff};
        `REG_OPEN_TMO: o_prdata <= {16'h0, open_tmo_ff};
        `REG_READ_TMO: o_prdata <= {16'h0, read_tmo_ff};
        `REG_TPWM_COEF: o_prdata <= {28'h0, tpwm_coef_ff};
        `REG_POUT_COEF: o_prdata <= {28'h0, pout_coef_ff};
        `REG_RANGE_TH: o_prdata <= {{(32-VW){1'b0}}, range_th_ff};
        `REG_IRQ_STAT: o_prdata <= {{(32-`EV_W){1'b0}}, irq_stat_ff};
        `REG_IRQ_MASK: o_prdata <= {{(32-`EV_W){1'b0}}, irq_mask_ff};
        `REG_STATUS: o_prdata <= {21'h0, open_fault_ff, tries_ff, 3'h0, state_ff};
        `REG_REF_CUR: o_prdata <= {{(32-VW){1'b0}}, o_ref_current};
        default: o_prdata <= 32'h00000000;
      endcase
    end
  end

  // Period, power and peak threshold filters
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tpwm_f_ff <= {(PW+2){1'b0}};
      pout_f_ff <= {(PW+2){1'b0}};
      peak_f_ff <= {(PW+2){1'b0}};
      o_peak_threshold <= {VW{1'b0}};
    end
    else
    begin
      if (i_period_done)
      begin
        tpwm_f_ff <= lp_filt(tpwm_f_ff, tpwm_x, tpwm_coef_ff);
        // Compared against limit times period, so the ratio stays exact
        pout_f_ff <= lp_filt(pout_f_ff, pout_x, pout_coef_ff);
      end
      peak_f_ff <= lp_filt(peak_f_ff, {{(PW+2-VW){1'b0}}, i_peak_thr_raw},
                           `PEAK_FILT_SHIFT);
      o_peak_threshold <= peak_f_ff[VW-1:0];
    end
  end

  // Gate on-time: high until peak reached or open timeout
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      on_ff <= 1'b0;
      on_cnt_ff <= {TW{1'b0}};
      o_gate <= 1'b0;
    end
    else
    begin
      if (!o_buck_en || i_peak_cmp || open_det)
        on_ff <= 1'b0;
      else if (i_on_start)
        on_ff <= 1'b1;
      if (i_on_start && !on_ff)
        on_cnt_ff <= {TW{1'b0}};
      else if (on_ff)
        on_cnt_ff <= on_cnt_ff + 1'b1;
      o_gate <= o_buck_en & ~i_peak_cmp & ~open_det & (on_ff | i_on_start);
    end
  end

  // Event sources for the sticky status
  always @*
  begin
    ev = {`EV_W{1'b0}};
    ev[`EV_UV] = fault & uv_det;
    ev[`EV_OPEN] = fault & open_det;
    ev[`EV_OV] = fault & ov_det;
    ev[`EV_OPW] = fault & opw_det;
    ev[`EV_LATCH] = fault & (tries_ff == `RESTART_TRIES);
  end

  // Next restart state
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:
        if (fault)
        begin
          if (tries_ff == `RESTART_TRIES)
            nxt_state = ST_LATCH;
          else if (open_det)
            nxt_state = ST_READ;
          else
            nxt_state = ST_DELAY;
        end
      ST_READ:
        if (timer_ff == 32'h00000000)
          nxt_state = ST_DELAY;
      ST_DELAY:
        if (timer_ff == 32'h00000000)
          nxt_state = ST_RUN;
      ST_LATCH:
        nxt_state = ST_LATCH;
      default:
        nxt_state = ST_RUN;
    endcase
    if (!enabled)
      nxt_state = ST_RUN;
  end

  // Restart sequencer, attempt counter and reference capture
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_ff <= ST_RUN;
      tries_ff <= 3'h0;
      open_fault_ff <= 1'b0;
      timer_ff <= 32'h00000000;
      o_ref_read_start <= 1'b0;
      o_ref_current <= {VW{1'b0}};
    end
    else
    begin
      state_ff <= nxt_state;
      o_ref_read_start <= 1'b0;
      if (!enabled)
      begin
        // Disabling is the only way out of the latch
        tries_ff <= 3'h0;
        timer_ff <= 32'h00000000;
      end
      else if (in_run && fault)
      begin
        open_fault_ff <= open_det;
        if (tries_ff != `RESTART_TRIES)
          tries_ff <= tries_ff + 1'b1;
        if (open_det)
        begin
          timer_ff <= {15'h0000, read_tmo_ff, 1'b0} - 32'h00000001;
          // No reading once the tries are spent and the latch follows
          o_ref_read_start <= (tries_ff != `RESTART_TRIES);
        end
        else
          timer_ff <= RESTART_CYC - 1;
      end
      else if (state_ff == ST_READ && timer_ff == 32'h00000000)
      begin
        o_ref_current <= i_iref_meas;
        timer_ff <= RESTART_CYC - 1;
      end
      else if (in_run)
      begin
        // A full restart time of clean running ends the episode
        if (timer_ff >= RESTART_CYC - 1)
          tries_ff <= 3'h0;
        else
          timer_ff <= timer_ff + 1'b1;
      end
      else if (timer_ff != 32'h00000000)
        timer_ff <= timer_ff - 1'b1;
      if (state_ff == ST_DELAY && timer_ff == 32'h00000000)
        timer_ff <= 32'h00000000;
    end
  end

  // Temperature current-level merge
  always @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_current_level <= `LEVEL_FULL;
    else if (!ctrl_ff[`CTRL_EXT_TEMP_EN])
      o_current_level <= i_int_temp_req ? i_int_temp_level : `LEVEL_FULL;
    else if (i_int_temp_req && i_ext_temp_req)
      o_current_level <= (i_int_temp_level < i_ext_temp_level) ?
                         i_int_temp_level : i_ext_temp_level;
    else if (i_int_temp_req)
      o_current_level <= i_int_temp_level;
    else if (i_ext_temp_req)
      o_current_level <= i_ext_temp_level;
    else
      o_current_level <= `LEVEL_FULL;
  end
endmodule

/* File: inc/fault_prot_defs.vh */
// Register map, field positions, reset values and constants of the fault supervisor
`ifndef FAULT_PROT_DEFS_VH
`define FAULT_PROT_DEFS_VH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_VOUT_MIN 8'h04
`define REG_VOUT_MAX 8'h08
`define REG_POUT_MAX 8'h0C
`define REG_OPEN_TMO 8'h10
`define REG_READ_TMO 8'h14
`define REG_TPWM_COEF 8'h18
`define REG_POUT_COEF 8'h1C
`define REG_RANGE_TH 8'h20
`define REG_IRQ_STAT 8'h24
`define REG_IRQ_MASK 8'h28
`define REG_STATUS 8'h2C
`define REG_REF_CUR 8'h30
// CTRL fields
`define CTRL_EN 0
`define CTRL_EXT_TEMP_EN 1
`define CTRL_RST 2'h0
// Event bits of IRQ_STAT and IRQ_MASK
`define EV_UV 0
`define EV_OPEN 1
`define EV_OV 2
`define EV_OPW 3
`define EV_LATCH 4
`define EV_W 5
// Reset values of programmable settings
`define VOUT_MIN_RST 16'h0100
`define VOUT_MAX_RST 16'h0F00
`define POUT_MAX_RST 16'h8000
`define OPEN_TMO_RST 16'h0400
`define READ_TMO_RST 16'h0800
`define COEF_RST 4'h3
`define RANGE_TH_RST 12'h800
// Built-in constants
`define RESTART_TRIES 3'h4
`define RESTART_TIME_US 1000
`define CLK_MHZ 20
`define LIMIT_LC_FACTOR 8'hE0
`define LIMIT_HC_FACTOR 8'hFF
`define FACTOR_SHIFT 8
`define PEAK_FILT_SHIFT 4'h4
`define LEVEL_FULL 8'hFF
`endif

/* File: bench/fault_prot_properties.sv */
// Port checker of the output fault supervisor, with its bind
`timescale 1ns/1ps
module fault_prot_properties (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_psel,
  input wire i_penable,
  input wire [7:0] i_paddr,
  input wire o_pslverr,
  input wire i_on_start,
  input wire i_peak_cmp,
  input wire o_buck_en,
  input wire o_gate,
  input wire o_ref_read_start,
  input wire i_int_temp_req,
  input wire i_ext_temp_req,
  input wire [7:0] i_int_temp_level,
  input wire [7:0] o_current_level
);
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // Gate drive around the on-time
  chk_gate_rise: assert property (i_on_start && o_buck_en && !i_peak_cmp |=> o_gate)
    else $error("gate not raised after on start");
  chk_gate_peak: assert property (o_gate && i_peak_cmp |=> !o_gate)
    else $error("gate still high after peak");
  // Reading pulse is single and the converter stays off from it through the next 7 cycles
  chk_read_pulse: assert property (o_ref_read_start |=> !o_ref_read_start)
    else $error("read start pulse too long");
  chk_read_first: assert property (o_ref_read_start |-> !o_buck_en [*8])
    else $error("converter on during reading");
  // Merged level, registered one cycle
  chk_temp_none: assert property (!i_int_temp_req && !i_ext_temp_req |=> o_current_level == 8'hFF)
    else $error("level not full without requests");
  chk_temp_int: assert property (i_int_temp_req && !i_ext_temp_req
    |=> o_current_level == $past(i_int_temp_level))
    else $error("internal level not applied");
  chk_temp_low: assert property (i_int_temp_req && i_ext_temp_req
    |=> o_current_level <= $past(i_int_temp_level))
    else $error("level above internal request");
  // Bus error only for places outside the map
  chk_err_unmap: assert property (i_psel && i_penable && i_paddr > 8'h30 |-> o_pslverr)
    else $error("unmapped access not refused");
  chk_err_none: assert property (i_psel && i_penable && i_paddr <= 8'h30
    && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
    else $error("mapped access refused");
endmodule

bind fault_prot fault_prot_properties fault_prot_properties_inst (.i_sys_clk, .i_rstn, .i_psel,
  .i_penable, .i_paddr, .o_pslverr, .i_on_start, .i_peak_cmp, .o_buck_en, .o_gate,
  .o_ref_read_start, .i_int_temp_req, .i_ext_temp_req, .i_int_temp_level, .o_current_level);

/* File: bench/tb_fault_prot.sv */
// Self-checking bench of the output fault supervisor
`timescale 1ns/1ps
module tb_fault_prot;
  localparam RC = 40;
  localparam [32:0] ALL = 33'h1FFFFFFFF;
  reg clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pdone = 1'b0;
  reg onst = 1'b0, peak = 1'b0, ssd = 1'b0, itr = 1'b0, etr = 1'b0, xen;
  reg [7:0] addr = 8'h00, itl = 8'h00, etl = 8'h00, el;
  reg [31:0] wd = 32'h0;
  reg [11:0] iout = 12'h000, iref = 12'h000, praw = 12'h800;
  reg [15:0] ton = 16'h0200;
  wire prdy, perr, buck, gate, rrs, irq;
  wire [31:0] prd;
  wire [11:0] rcur, pthr;
  wire [7:0] lvl;
  reg [32:0] exq[$], mkq[$];
  integer fails = 0, check_count = 0, n, k, lowc = 0, last = 0;

  // Short restart delay keeps the run brief
  fault_prot #(.RESTART_CYC(RC)) fault_prot_inst (.i_sys_clk(clk), .i_rstn(rstn),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd),
    .o_pready(prdy), .o_prdata(prd), .o_pslverr(perr), .i_vin(12'h100), .i_iout(iout),
    .i_ton(ton), .i_tpwm(16'h0100), .i_period_done(pdone), .i_on_start(onst),
    .i_peak_cmp(peak), .i_peak_thr_raw(praw), .i_soft_start_done(ssd),
    .i_iref_meas(iref), .i_int_temp_req(itr), .i_int_temp_level(itl),
    .i_ext_temp_req(etr), .i_ext_temp_level(etl), .o_buck_en(buck), .o_gate(gate),
    .o_ref_read_start(rrs), .o_ref_current(rcur), .o_peak_threshold(pthr),
    .o_current_level(lvl), .o_irq(irq));

  initial forever #25 clk = ~clk;

  task cmp(input string nm, input [32:0] e, input [32:0] g, input [32:0] m);
    begin
      check_count = check_count + 1;
      if (((e ^ g) & m) !== 33'h0)
      begin
        fails = fails + 1;
        $display("MISMATCH %s exp %h got %h", nm, e & m, g & m);
      end
    end
  endtask

  // Length of the last converter-off stretch
  always @(posedge clk)
    if (buck !== 1'b1)
      lowc <= lowc + 1;
    else if (lowc != 0)
    begin
      last <= lowc;
      lowc <= 0;
    end

  // Read results against the oldest note
  always @(posedge clk)
    if (psel && pen && !pwr && prdy)
      cmp("read", exq.pop_front(), {perr, prd}, mkq.pop_front());

  // One transfer; idle edge after it avoids double drives
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      @(posedge clk);
      while (prdy !== 1'b1 && n < 50)
      begin
        @(posedge clk);
        n = n + 1;
      end
      // A wait that ran out shows as a mismatch here
      cmp("pready", 1, prdy, 1);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rd(input [7:0] a, input [32:0] e, input [32:0] m);
    begin
      exq.push_back(e);
      mkq.push_back(m);
      apb(1'b0, a, 32'h0);
    end
  endtask

  task per(input [15:0] t, input [11:0] c);
    begin
      ton <= t;
      iout <= c;
      pdone <= 1'b1;
      @(posedge clk);
      pdone <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Five faults of one kind: four restarts, then the latch
  task ep(input o, input [15:0] t, input [11:0] c, input [4:0] ev);
    begin
      for (k = 0; k < 5; k = k + 1)
      begin
        iref <= $urandom;
        if (o)
        begin
          onst <= 1'b1;
          @(posedge clk);
          onst <= 1'b0;
          repeat (14) @(posedge clk);
        end
        else
          per(t, c);
        rd(8'h2C, (k < 4) ? {o, k[2:0] + 3'h1, 7'h04} : 33'h8,
          (k < 4) ? (o ? 33'h780 : 33'h78F) : 33'hF);
        // Clean period during the delay clears the stale filtered power
        if (!o)
          per(16'h0200, 12'h000);
        n = 0;
        while (k < 4 && buck !== 1'b1 && n < 300)
        begin
          @(posedge clk);
          n = n + 1;
        end
        @(posedge clk);
        if (k < 4)
          cmp("offtime", 1, last >= (o ? RC + 8 : RC) && last <= (o ? RC + 10 : RC + 1), 1);
        if (o && k < 4)
        begin
          rd(8'h30, iref, 33'hFFF);
          cmp("ref_current", iref, rcur, 33'hFFF);
        end
      end
      rd(8'h24, {28'h0, 5'h10 | ev}, 33'h1F);
      cmp("buck", 0, buck, 1);
      cmp("irq", 1, irq, 1);
      apb(1'b1, 8'h28, 32'h0);
      cmp("irq", 0, irq, 1);
      apb(1'b1, 8'h24, 32'h1F);
      apb(1'b1, 8'h28, 32'h1F);
      cmp("irq", 0, irq, 1);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h00, 32'h3);
    end
  endtask

  task close_out;
    begin
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    close_out;
  end

  initial
  begin
    k = $urandom(67833);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset values, then a refused unmapped place
    rd(8'h04, 33'h100, ALL);
    rd(8'h08, 33'hF00, ALL);
    rd(8'h10, 33'h400, ALL);
    rd(8'h14, 33'h800, ALL);
    rd(8'h40, 33'h100000000, ALL);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h1C, 32'h0);
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h10, 32'hA);
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b1, 8'h28, 32'h1F);
    apb(1'b1, 8'h00, 32'h3);
    // Low output before soft-start must pass unseen
    per(16'h0200, 12'h000);
    per(16'h0080, 12'h000);
    rd(8'h24, 33'h0, ALL);
    ssd <= 1'b1;
    ep(1'b0, 16'h0080, 12'h000, 5'h01);
    ep(1'b0, 16'h1000, 12'h000, 5'h04);
    ep(1'b0, 16'h0200, 12'hFFF, 5'h08);
    ep(1'b1, 16'h0200, 12'h000, 5'h02);
    // On-time ended by the peak comparator
    onst <= 1'b1;
    @(posedge clk);
    onst <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("gate", 1, gate, 1);
    peak <= 1'b1;
    repeat (2) @(posedge clk);
    cmp("gate", 0, gate, 1);
    peak <= 1'b0;
    // Random requests, external sensor on, then off
    for (k = 0; k < 24; k = k + 1)
    begin
      if (k == 12)
        apb(1'b1, 8'h00, 32'h1);
      xen = (k < 12);
      n = $urandom;
      itr <= n[0];
      etr <= n[1];
      itl <= n[15:8];
      etl <= n[23:16];
      repeat (3) @(posedge clk);
      el = (etr && xen) ? ((itr && itl < etl) ? itl : etl) : (itr ? itl : 8'hFF);
      cmp("level", el, lvl, 33'hFF);
    end
    // Threshold filter settles on the raw level, rising and falling
    cmp("peak_thr", 1, pthr >= 12'h7F1 && pthr <= 12'h800, 1);
    praw <= 12'h100;
    repeat (300) @(posedge clk);
    cmp("peak_thr", 12'h100, pthr, 33'hFFF);
    close_out;
  end
endmodule
